// *** logic/cpu_bitcond_pkg.sv ***
package cpu_bitcond_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int HALF_W = 16;
  localparam int IMM_W  = 16;

  // Left shift applied to the index value per prefix scaling
  localparam logic [1:0] SCALE_BYTE = 2'h0;
  localparam logic [1:0] SCALE_WORD = 2'h1;
  localparam logic [1:0] SCALE_LONG = 2'h2;

  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_RST   = 24'h00_0000;
  localparam logic [IMM_W-1:0]  IMM_RST    = 16'h0000;

  typedef enum logic [3:0] {
    op_none,
    op_mem,
    op_cond_bit_store,
    op_sign_widen_b,
    op_sign_widen_w,
    op_sign_widen_b2,
    op_zero_widen,
    op_byte_index_prefix,
    op_word_index_prefix,
    op_long_index_prefix,
    op_bit_position_prefix,
    op_frame_build
  } op_e;

  typedef enum logic [3:0] {
    unsigned_ge,
    unsigned_gt,
    zero_set,
    sign_set,
    signed_at_most,
    overflow_set,
    signed_at_least,
    unsigned_lt,
    unsigned_le,
    nonzero,
    sign_clear,
    signed_above,
    overflow_clear,
    signed_below
  } cond_e;

  typedef enum logic [1:0] {
    var_both,
    var_dst,
    var_src
  } variant_e;

  typedef enum logic [1:0] {
    pfx_none,
    pfx_addr,
    pfx_bit
  } pfx_e;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic overflow;
  } flags_s;

  typedef struct packed {
    logic              valid;
    op_e               op;
    cond_e             cond;
    variant_e          variant;
    logic              to_carry;
    logic              src_word;
    logic              d_uses_src;
    logic [DATA_W-1:0] src_val;
    logic [DATA_W-1:0] dst_val;
    logic [ADDR_W-1:0] src_addr;
    logic [ADDR_W-1:0] dst_addr;
    logic [IMM_W-1:0]  imm;
  } req_s;

  typedef struct packed {
    logic              done;
    op_e               op;
    logic              result_wr;
    logic [DATA_W-1:0] result;
    logic              bit_wr;
    logic              carry_wr;
    logic              bit_val;
    logic [ADDR_W-1:0] src_ea;
    logic [ADDR_W-1:0] dst_ea;
    logic              bit_pos_valid;
    logic [HALF_W-1:0] bit_pos;
    logic              frame_wr;
    logic [IMM_W-1:0]  frame_bytes;
  } resp_s;

endpackage

// *** logic/cpu_bitcond_extend_index_unit.sv ***
module cpu_bitcond_extend_index_unit
  import cpu_bitcond_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst,
  input  wire flags_s flags,
  input  wire req_s   req,
  output resp_s       resp,
  output logic        prefix_pending
);

  // Prefix state, held between the prefix and the instruction it modifies
  pfx_e              pfx_reg;
  pfx_e              pfx_next;
  variant_e          pfx_var_reg;
  variant_e          pfx_var_next;
  logic [1:0]        pfx_scale_reg;
  logic [1:0]        pfx_scale_next;
  logic [HALF_W-1:0] pfx_val_reg;
  logic [HALF_W-1:0] pfx_val_next;
  resp_s             resp_reg;
  resp_s             resp_next;

  // Condition evaluation; operand values never enter here
  wire logic c_f  = flags.carry;
  wire logic z_f  = flags.zero;
  wire logic s_f  = flags.sign;
  wire logic o_f  = flags.overflow;
  wire logic s_eq_o = (s_f == o_f);
  logic      cond_true;

  always_comb begin
    unique case (req.cond)
      unsigned_ge:     cond_true = c_f;
      unsigned_lt:     cond_true = ~c_f;
      unsigned_gt:     cond_true = c_f & ~z_f;
      unsigned_le:     cond_true = ~c_f | z_f;
      zero_set:        cond_true = z_f;
      nonzero:         cond_true = ~z_f;
      sign_set:        cond_true = s_f;
      sign_clear:      cond_true = ~s_f;
      overflow_set:    cond_true = o_f;
      overflow_clear:  cond_true = ~o_f;
      signed_at_least: cond_true = s_eq_o;
      signed_below:    cond_true = ~s_eq_o;
      signed_at_most:  cond_true = z_f | ~s_eq_o;
      signed_above:    cond_true = ~z_f & s_eq_o;
      // Two spare codes; treat as false so nothing undefined is stored
      default:         cond_true = 1'b0;
    endcase
  end

  // Widening datapath
  wire logic [DATA_W-1:0] sx_byte_dst =
    {{(DATA_W-HALF_W){1'b0}}, {BYTE_W{req.dst_val[BYTE_W-1]}}, req.dst_val[BYTE_W-1:0]};
  wire logic [DATA_W-1:0] sx_word_dst =
    {{HALF_W{req.dst_val[HALF_W-1]}}, req.dst_val[HALF_W-1:0]};
  // Source is only read; the write goes to the destination
  wire logic [DATA_W-1:0] sx_byte_src =
    {{(DATA_W-HALF_W){1'b0}}, {BYTE_W{req.src_val[BYTE_W-1]}}, req.src_val[BYTE_W-1:0]};
  wire logic [DATA_W-1:0] zx_byte_src =
    {{(DATA_W-BYTE_W){1'b0}}, req.src_val[BYTE_W-1:0]};

  // Prefix operand: .B takes a byte, .W a word, always zero-filled
  wire logic [HALF_W-1:0] idx_raw =
    req.src_word ? req.src_val[HALF_W-1:0] : {{(HALF_W-BYTE_W){1'b0}}, req.src_val[BYTE_W-1:0]};

  // Scaled offset, widened without sign before the add
  wire logic [ADDR_W-1:0] idx_zext   = {{(ADDR_W-HALF_W){1'b0}}, pfx_val_reg};
  wire logic [ADDR_W-1:0] idx_scaled =
    (pfx_scale_reg == SCALE_LONG) ? ADDR_W'(idx_zext << 2) :
    (pfx_scale_reg == SCALE_WORD) ? ADDR_W'(idx_zext << 1) :
                                    idx_zext;

  wire logic is_prefix = (req.op == op_byte_index_prefix) || (req.op == op_word_index_prefix) ||
                         (req.op == op_long_index_prefix) || (req.op == op_bit_position_prefix);
  wire logic is_instr  = req.valid && (req.op != op_none) && !is_prefix;

  // Which address the pending offset lands on
  wire logic addr_pfx  = (pfx_reg == pfx_addr);
  wire logic hit_src   = addr_pfx && ((pfx_var_reg == var_both) || (pfx_var_reg == var_src) ||
                                      ((pfx_var_reg == var_dst) && req.d_uses_src));
  wire logic hit_dst   = addr_pfx && ((pfx_var_reg == var_both) ||
                                      ((pfx_var_reg == var_dst) && !req.d_uses_src));

  // Effective addresses resolved in the cycle the instruction is decoded
  wire logic [ADDR_W-1:0] src_ea = hit_src ? ADDR_W'(req.src_addr + idx_scaled) : req.src_addr;
  wire logic [ADDR_W-1:0] dst_ea = hit_dst ? ADDR_W'(req.dst_addr + idx_scaled) : req.dst_addr;
  wire logic              bit_pfx = (pfx_reg == pfx_bit);

  // Prefix state update
  always_comb begin
    pfx_next       = pfx_reg;
    pfx_var_next   = pfx_var_reg;
    pfx_scale_next = pfx_scale_reg;
    pfx_val_next   = pfx_val_reg;
    if (req.valid && is_prefix) begin
      pfx_val_next = idx_raw;
      pfx_var_next = req.variant;
      unique case (req.op)
        op_byte_index_prefix: begin
          pfx_next       = pfx_addr;
          pfx_scale_next = SCALE_BYTE;
        end
        op_word_index_prefix: begin
          pfx_next       = pfx_addr;
          pfx_scale_next = SCALE_WORD;
        end
        op_long_index_prefix: begin
          pfx_next       = pfx_addr;
          pfx_scale_next = SCALE_LONG;
        end
        default: begin
          pfx_next       = pfx_bit;
          pfx_scale_next = SCALE_BYTE;
        end
      endcase
    end else if (is_instr) begin
      // One instruction only; completes this cycle, so the prefix is spent
      pfx_next = pfx_none;
    end
  end

  // Result formation
  always_comb begin
    resp_next               = '0;
    resp_next.op            = req.op;
    resp_next.done          = is_instr;
    resp_next.src_ea        = src_ea;
    resp_next.dst_ea        = dst_ea;
    resp_next.bit_pos_valid = is_instr && bit_pfx;
    // Only reported with the instruction that consumes the prefix
    resp_next.bit_pos       = (is_instr && bit_pfx) ? pfx_val_reg : '0;
    if (is_instr) begin
      unique case (req.op)
        op_cond_bit_store: begin
          resp_next.bit_val  = cond_true;
          resp_next.carry_wr = req.to_carry;
          resp_next.bit_wr   = !req.to_carry;
        end
        op_sign_widen_b: begin
          resp_next.result    = sx_byte_dst;
          resp_next.result_wr = 1'b1;
        end
        op_sign_widen_w: begin
          resp_next.result    = sx_word_dst;
          resp_next.result_wr = 1'b1;
        end
        op_sign_widen_b2: begin
          resp_next.result    = sx_byte_src;
          resp_next.result_wr = 1'b1;
        end
        op_zero_widen: begin
          resp_next.result    = zx_byte_src;
          resp_next.result_wr = 1'b1;
        end
        op_frame_build: begin
          resp_next.frame_bytes = req.imm;
          resp_next.frame_wr    = 1'b1;
        end
        default: begin
          // Plain memory instruction: only the effective addresses matter
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pfx_reg       <= pfx_none;
      pfx_var_reg   <= var_both;
      pfx_scale_reg <= SCALE_BYTE;
      pfx_val_reg   <= IMM_RST;
      resp_reg      <= '0;
    end else begin
      pfx_reg       <= pfx_next;
      pfx_var_reg   <= pfx_var_next;
      pfx_scale_reg <= pfx_scale_next;
      pfx_val_reg   <= pfx_val_next;
      resp_reg      <= resp_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prefix_pending <= 1'b0;
    end else begin
      prefix_pending <= (pfx_next != pfx_none);
    end
  end

  assign resp = resp_reg;

endmodule // cpu_bitcond_extend_index_unit

// *** tb/cpu_bitcond_checker.sv ***
module cpu_bitcond_checker
  import cpu_bitcond_pkg::*;
(
  input wire logic   core_clk,
  input wire logic   rst,
  input wire flags_s flags,
  input wire req_s   req,
  input wire resp_s  resp,
  input wire logic   prefix_pending
);
  wire take = req.valid && req.op != op_none;
  wire pfx  = req.op inside {op_byte_index_prefix, op_word_index_prefix, op_long_index_prefix,
                             op_bit_position_prefix};
  wire cbs  = take && req.op == op_cond_bit_store;
  wire ge   = flags.sign ~^ flags.overflow;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_done_follows: assert property (take && !pfx |=> resp.done)
    else $error("no done after instruction");
  a_prefix_waits: assert property (take && pfx |=> prefix_pending)
    else $error("prefix not held");
  a_prefix_once: assert property (prefix_pending && take && !pfx |=> !prefix_pending)
    else $error("prefix outlived its instruction");
  a_ugt_cond: assert property (cbs && req.cond == unsigned_gt |=>
    resp.bit_val == $past(flags.carry & ~flags.zero)) else $error("unsigned_gt wrong");
  a_below_cond: assert property (cbs && req.cond == signed_below |=> resp.bit_val == !$past(ge))
    else $error("signed_below wrong");
  a_above_cond: assert property (cbs && req.cond == signed_above |=>
    resp.bit_val == $past(ge & ~flags.zero)) else $error("signed_above wrong");
  a_word_widen: assert property (take && req.op == op_sign_widen_w |=>
    resp.result == {{16{$past(req.dst_val[15])}}, $past(req.dst_val[15:0])}) else $error("word widen wrong");
  a_zero_fill: assert property (take && req.op == op_zero_widen |=> resp.result[31:8] == 24'h0)
    else $error("zero widen upper bits set");
  a_frame_size: assert property (take && req.op == op_frame_build |=>
    resp.frame_wr && resp.frame_bytes == $past(req.imm)) else $error("frame size wrong");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !resp.done && !prefix_pending)
    else $error("activity after reset");
  c_prefix_pair: cover property (take && pfx ##1 take && !pfx);
  c_cond_store: cover property (cbs && req.to_carry);
  c_frame: cover property (take && req.op == op_frame_build);
endmodule // cpu_bitcond_checker

bind cpu_bitcond_extend_index_unit cpu_bitcond_checker chk_i (
  .core_clk(core_clk), .rst(rst), .flags(flags), .req(req), .resp(resp), .prefix_pending(prefix_pending));

// *** tb/cpu_bitcond_extend_index_unit_tb_top.sv ***
module cpu_bitcond_extend_index_unit_tb_top
  import cpu_bitcond_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0;
  logic        rst = 1;
  flags_s      flags = '0;
  req_s        req = '0;
  resp_s       resp;
  resp_s       ex = '0;
  logic        prefix_pending;
  logic [31:0] r;
  logic [23:0] off;
  int          failures = 0;
  int          n_checks = 0;
  int          pend = 0;
  int          pv, ps, pw, cyc = 0;

  always #2 core_clk = ~core_clk;

  cpu_bitcond_extend_index_unit dut (.core_clk(core_clk), .rst(rst), .flags(flags), .req(req),
                                     .resp(resp), .prefix_pending(prefix_pending));

  function automatic logic cond_ok(cond_e c, flags_s f);
    case (c)
      unsigned_ge:    return f.carry;
      unsigned_lt:    return !f.carry;
      unsigned_gt:    return f.carry && !f.zero;
      unsigned_le:    return !f.carry || f.zero;
      zero_set:       return f.zero;
      nonzero:        return !f.zero;
      sign_set:       return f.sign;
      sign_clear:     return !f.sign;
      overflow_set:   return f.overflow;
      overflow_clear: return !f.overflow;
      signed_at_least: return f.sign == f.overflow;
      signed_below:   return f.sign != f.overflow;
      signed_at_most: return f.zero || f.sign != f.overflow;
      signed_above:   return !f.zero && f.sign == f.overflow;
      default:        return 1'b0;
    endcase
  endfunction

  task automatic chk(logic [63:0] got, logic [63:0] exp, string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    void'($urandom(47840));
    #16000;
    failures++;
    conclude();
  end

  always @(posedge core_clk) begin
    ex = '0;
    ex.src_ea = req.src_addr;
    ex.dst_ea = req.dst_addr;
    if (rst) pend = 0;
    else if (req.valid && req.op != op_none) begin
      if (req.op >= op_byte_index_prefix && req.op <= op_bit_position_prefix) begin
        pend = (req.op == op_bit_position_prefix) ? 2 : 1;
        pw = req.src_word ? req.src_val[15:0] : req.src_val[7:0];
        ps = req.op - op_byte_index_prefix;
        pv = req.variant;
      end else begin
        ex.done = 1;
        ex.op = req.op;
        off = 24'(pw << ps);
        if (pend == 1 && (pv != var_dst || req.d_uses_src)) ex.src_ea += off;
        if (pend == 1 && (pv == var_both || (pv == var_dst && !req.d_uses_src))) ex.dst_ea += off;
        ex.bit_pos_valid = pend == 2;
        ex.bit_pos = ex.bit_pos_valid ? 16'(pw) : 16'h0;
        pend = 0;
        ex.result_wr = req.op inside {op_sign_widen_b, op_sign_widen_w, op_sign_widen_b2, op_zero_widen};
        case (req.op)
          op_sign_widen_b:  ex.result = {16'h0, {8{req.dst_val[7]}}, req.dst_val[7:0]};
          op_sign_widen_w:  ex.result = {{16{req.dst_val[15]}}, req.dst_val[15:0]};
          op_sign_widen_b2: ex.result = {16'h0, {8{req.src_val[7]}}, req.src_val[7:0]};
          op_zero_widen:    ex.result = {24'h0, req.src_val[7:0]};
          default:          ex.result = '0;
        endcase
        ex.bit_val = req.op == op_cond_bit_store && cond_ok(req.cond, flags);
        ex.bit_wr = req.op == op_cond_bit_store && !req.to_carry;
        ex.carry_wr = req.op == op_cond_bit_store && req.to_carry;
        ex.frame_wr = req.op == op_frame_build;
        ex.frame_bytes = ex.frame_wr ? req.imm : 16'h0;
      end
    end
    cyc++;
    r = $urandom;
    rst <= (cyc < 6) || (cyc >= 1500 && cyc < 1503);
    flags <= flags_s'(r[19:16]);
    req.valid <= r[0] | r[1];
    req.op <= op_e'(1 + r[5:2] % 11);
    req.cond <= cond_e'(r[9:6]);
    req.variant <= variant_e'(r[11:10] % 3);
    req.to_carry <= r[12];
    req.src_word <= r[13];
    // Held across a prefix pair, since the prefix and its instruction must agree
    if (pend == 0) req.d_uses_src <= r[14];
    req.src_val <= $urandom;
    req.dst_val <= $urandom;
    req.src_addr <= r[15] ? 24'hff_fff0 : 24'($urandom);
    req.dst_addr <= r[20] ? 24'hff_ffe0 : 24'($urandom);
    req.imm <= 16'($urandom);
    if (cyc == 3000) conclude();
  end

  always @(negedge core_clk) if (cyc > 0) begin
    chk(resp.done, ex.done, "done");
    chk(prefix_pending, pend != 0, "prefix pending");
    chk({resp.result_wr, resp.result}, {ex.result_wr, ex.result}, "widen result");
    chk({resp.bit_wr, resp.carry_wr, resp.bit_val}, {ex.bit_wr, ex.carry_wr, ex.bit_val}, "bit store");
    chk({resp.bit_pos_valid, resp.bit_pos}, {ex.bit_pos_valid, ex.bit_pos}, "bit position");
    chk({resp.frame_wr, resp.frame_bytes}, {ex.frame_wr, ex.frame_bytes}, "frame size");
    if (ex.done) begin
      chk({resp.op, resp.src_ea}, {ex.op, ex.src_ea}, "source address");
      chk(resp.dst_ea, ex.dst_ea, "destination address");
    end
  end
endmodule // cpu_bitcond_extend_index_unit_tb_top
